// ==== design/urbg_baud_div.sv ====
// Baud generator: optional divide-by-four prescale, then divisor.
// Assumes a one-cycle source tick already in the I_CLK domain.
`timescale 1ns/1ps
`default_nettype none
`include "urbg_consts.svh"
module urbg_baud_div
  import urbg_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_enable,
  input  wire logic       i_prescale4,
  input  wire urbg_div_t  i_divisor,
  input  wire logic       i_src_tick,
  // Result
  output logic            o_sample_tick
);
  logic [1:0] pre_r;
  logic [1:0] pre_nxt;
  urbg_div_t  cnt_r;
  urbg_div_t  cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic       pre_tick;

  // ==========================================================
  // Divider
  always_comb begin
    pre_nxt  = pre_r;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    pre_tick = 1'b0;
    if (i_src_tick) begin
      pre_nxt  = pre_r + 2'h1;
      pre_tick = !i_prescale4 || (pre_r == `URBG_PRESCALE_LAST);
    end
    if (!i_enable || (i_divisor == 16'h0000)) begin
      cnt_nxt = 16'h0000;
    end else if (pre_tick) begin
      if (cnt_r >= (i_divisor - 16'h0001)) begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_r  <= 2'h0;
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_sample_tick = tick_r;
endmodule
`default_nettype wire

// ==== design/urbg_consts.svh ====
// Constants of the channel ready-signal and baud-rate block.
// Assumes inclusion by bare name from design and testbench files.
`ifndef URBG_CONSTS_SVH
`define URBG_CONSTS_SVH

// ==========================================================
// Register byte offsets on the APB side
`define URBG_ADDR_DATA      8'h00
`define URBG_ADDR_FIFO_CTL  8'h04
`define URBG_ADDR_LINE_CTL  8'h08
`define URBG_ADDR_MODEM_CTL 8'h0C
`define URBG_ADDR_LINE_STAT 8'h10
`define URBG_ADDR_DIV_LO    8'h14
`define URBG_ADDR_DIV_HI    8'h18

// ==========================================================
// Field positions
`define URBG_FIFO_EN         0
`define URBG_FIFO_RXCLR      1
`define URBG_FIFO_TXCLR      2
`define URBG_FIFO_BLOCK      3
`define URBG_FIFO_TRIG_LO    6
`define URBG_FIFO_TRIG_HI    7
`define URBG_MODEM_PRESCALE  7
`define URBG_STAT_DATA_RDY   0
`define URBG_STAT_HOLD_EMPTY 5
`define URBG_STAT_TX_EMPTY   6

// ==========================================================
// Reset values and fifo control write mask
`define URBG_FIFO_CTL_RST   8'h00
`define URBG_LINE_CTL_RST   8'h00
`define URBG_MODEM_CTL_RST  8'h00
`define URBG_FIFO_WMASK     8'hC9

// ==========================================================
// FIFO sizes and trigger levels
`define URBG_DEPTH          5'h10
`define URBG_SINGLE_CAP     5'h01
`define URBG_TX_TRIG        5'h08
`define URBG_RX_TRIG_0      5'h01
`define URBG_RX_TRIG_1      5'h04
`define URBG_RX_TRIG_2      5'h08
`define URBG_RX_TRIG_3      5'h0E

// ==========================================================
// Timing counts
`define URBG_SAMPLES_LAST   4'hF
`define URBG_PRESCALE_LAST  2'h3
`define URBG_WL_BASE        6'h05
`define URBG_TO_EXTRA       6'h0C

`endif

// ==== design/urbg_pkg.sv ====
// Types shared by the channel ready-signal and baud-rate block.
// Assumes nothing of its surroundings.
package urbg_pkg;
  typedef logic [7:0]  urbg_byte_t;
  typedef logic [4:0]  urbg_cnt_t;
  typedef logic [3:0]  urbg_ptr_t;
  typedef logic [15:0] urbg_div_t;

  // Operating mode, one-hot
  typedef enum logic [2:0] {
    URBG_MODE_SINGLE = 3'b001,
    URBG_MODE_FIFO   = 3'b010,
    URBG_MODE_BLOCK  = 3'b100
  } urbg_mode_e;
endpackage

// ==== design/urbg_top.sv ====
// Channel ready signals, FIFOs, receive timeout and baud generator.
// Assumes shift logic on I_CLK and an oscillator pin on I_OSC_IN.
`timescale 1ns/1ps
`default_nettype none
`include "urbg_consts.svh"
module urbg_top
  import urbg_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Oscillator pin
  input  wire logic        I_OSC_IN,
  // Transmit shift logic
  input  wire logic        I_TX_POP,
  input  wire logic        I_TX_SHIFT_EMPTY,
  output urbg_pkg::urbg_byte_t O_TX_DATA,
  output logic             O_TX_VALID,
  // Receive shift logic
  input  wire logic        I_RX_PUSH,
  input  wire urbg_pkg::urbg_byte_t I_RX_DATA,
  // Timing ticks and word length
  output logic             O_SAMPLE_TICK,
  output logic             O_BIT_TICK,
  output logic [1:0]       O_WORD_LEN,
  // Channel pins
  output logic             O_TX_INT,
  output logic             O_RX_INT,
  output logic             O_TX_READY_N,
  output logic             O_RX_READY_N
);
  // ==========================================================
  // Declarations
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  urbg_byte_t  fifo_control_reg_r, fifo_control_reg_nxt, line_control_reg_r, line_control_reg_nxt;
  urbg_byte_t  modem_control_reg_r, modem_control_reg_nxt, div_lo_r, div_lo_nxt, div_hi_r, div_hi_nxt;
  logic [1:0]  div_set_r, div_set_nxt;
  urbg_byte_t  tx_mem_r [16];
  urbg_byte_t  tx_mem_nxt [16];
  urbg_byte_t  rx_mem_r [16];
  urbg_byte_t  rx_mem_nxt [16];
  urbg_ptr_t   tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  urbg_ptr_t   rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  urbg_cnt_t   tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  urbg_byte_t  tx_data_r;
  logic        tx_valid_r;
  logic [2:0]  osc_r, osc_nxt;
  logic [3:0]  samp_r, samp_nxt;
  logic        bit_tick_r, bit_tick_nxt;
  logic [5:0]  to_cnt_r, to_cnt_nxt;
  logic        to_flag_r, to_flag_nxt;
  logic        tx_int_r, tx_int_nxt, rx_int_r, rx_int_nxt;
  logic        tx_rdy_n_r, tx_rdy_n_nxt, rx_rdy_n_r, rx_rdy_n_nxt;
  logic        done, wr_done, rd_done, osc_tick, sample_tick;
  logic        tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
  urbg_cnt_t   cap, rx_trig;
  logic [5:0]  wl_bits, to_limit;
  urbg_mode_e  mode;

  // ==========================================================
  // Bus decode, mode and trigger selection
  assign done    = I_PSEL && I_PENABLE && pready_r;
  assign wr_done = done && I_PWRITE;
  assign rd_done = done && !I_PWRITE;
  assign mode    = !fifo_control_reg_r[`URBG_FIFO_EN] ? URBG_MODE_SINGLE :
                   (fifo_control_reg_r[`URBG_FIFO_BLOCK] ? URBG_MODE_BLOCK : URBG_MODE_FIFO);
  assign cap     = fifo_control_reg_r[`URBG_FIFO_EN] ? `URBG_DEPTH : `URBG_SINGLE_CAP;
  always_comb begin
    unique case (fifo_control_reg_r[`URBG_FIFO_TRIG_HI:`URBG_FIFO_TRIG_LO])
      2'h0:    rx_trig = `URBG_RX_TRIG_0;
      2'h1:    rx_trig = `URBG_RX_TRIG_1;
      2'h2:    rx_trig = `URBG_RX_TRIG_2;
      default: rx_trig = `URBG_RX_TRIG_3;
    endcase
  end

  // ==========================================================
  // APB slave and control registers
  always_comb begin
    pready_nxt  = I_PSEL && I_PENABLE && !pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    fifo_control_reg_nxt  = fifo_control_reg_r;
    line_control_reg_nxt  = line_control_reg_r;
    modem_control_reg_nxt = modem_control_reg_r;
    div_lo_nxt  = div_lo_r;
    div_hi_nxt  = div_hi_r;
    div_set_nxt = div_set_r;
    tx_clr      = 1'b0;
    rx_clr      = 1'b0;
    if (I_PSEL && I_PENABLE && !pready_r) begin
      prdata_nxt = 32'h0000_0000;
      unique case (I_PADDR)
        `URBG_ADDR_DATA:      prdata_nxt[7:0] = rx_mem_r[rx_rp_r];
        `URBG_ADDR_FIFO_CTL:  prdata_nxt[7:0] = fifo_control_reg_r;
        `URBG_ADDR_LINE_CTL:  prdata_nxt[7:0] = line_control_reg_r;
        `URBG_ADDR_MODEM_CTL: prdata_nxt[7:0] = modem_control_reg_r;
        `URBG_ADDR_LINE_STAT: begin
          prdata_nxt[`URBG_STAT_DATA_RDY]   = (rx_cnt_r != 5'h00);
          prdata_nxt[`URBG_STAT_HOLD_EMPTY] = (tx_cnt_r == 5'h00);
          prdata_nxt[`URBG_STAT_TX_EMPTY]   = (tx_cnt_r == 5'h00) && I_TX_SHIFT_EMPTY;
        end
        `URBG_ADDR_DIV_LO:    prdata_nxt[7:0] = div_lo_r;
        `URBG_ADDR_DIV_HI:    prdata_nxt[7:0] = div_hi_r;
        default:              pslverr_nxt = 1'b1;
      endcase
    end
    if (wr_done) begin
      unique case (I_PADDR)
        `URBG_ADDR_FIFO_CTL: begin
          fifo_control_reg_nxt = I_PWDATA[7:0] & `URBG_FIFO_WMASK;
          tx_clr  = I_PWDATA[`URBG_FIFO_TXCLR] || (I_PWDATA[`URBG_FIFO_EN] != fifo_control_reg_r[`URBG_FIFO_EN]);
          rx_clr  = I_PWDATA[`URBG_FIFO_RXCLR] || (I_PWDATA[`URBG_FIFO_EN] != fifo_control_reg_r[`URBG_FIFO_EN]);
        end
        `URBG_ADDR_LINE_CTL:  line_control_reg_nxt  = I_PWDATA[7:0];
        `URBG_ADDR_MODEM_CTL: modem_control_reg_nxt = I_PWDATA[7:0];
        `URBG_ADDR_DIV_LO: begin
          div_lo_nxt     = I_PWDATA[7:0];
          div_set_nxt[0] = 1'b1;
        end
        `URBG_ADDR_DIV_HI: begin
          div_hi_nxt     = I_PWDATA[7:0];
          div_set_nxt[1] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    div_lo_r <= div_lo_nxt;
    div_hi_r <= div_hi_nxt;
    if (I_SYS_RST) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      fifo_control_reg_r  <= `URBG_FIFO_CTL_RST;
      line_control_reg_r  <= `URBG_LINE_CTL_RST;
      modem_control_reg_r <= `URBG_MODEM_CTL_RST;
      div_set_r <= 2'h0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      fifo_control_reg_r  <= fifo_control_reg_nxt;
      line_control_reg_r  <= line_control_reg_nxt;
      modem_control_reg_r <= modem_control_reg_nxt;
      div_set_r <= div_set_nxt;
    end
  end

  // ==========================================================
  // Transmit and receive FIFOs
  assign tx_push = wr_done && (I_PADDR == `URBG_ADDR_DATA) && (tx_cnt_r < cap);
  assign tx_pop  = I_TX_POP && (tx_cnt_r != 5'h00);
  assign rx_push = I_RX_PUSH && (rx_cnt_r < cap);
  assign rx_pop  = rd_done && (I_PADDR == `URBG_ADDR_DATA) && (rx_cnt_r != 5'h00);

  always_comb begin
    tx_mem_nxt = tx_mem_r;
    rx_mem_nxt = rx_mem_r;
    tx_wp_nxt  = tx_wp_r + {3'h0, tx_push};
    tx_rp_nxt  = tx_rp_r + {3'h0, tx_pop};
    rx_wp_nxt  = rx_wp_r + {3'h0, rx_push};
    rx_rp_nxt  = rx_rp_r + {3'h0, rx_pop};
    tx_cnt_nxt = tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
    rx_cnt_nxt = rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
    if (tx_push) begin
      tx_mem_nxt[tx_wp_r] = I_PWDATA[7:0];
    end
    if (rx_push) begin
      rx_mem_nxt[rx_wp_r] = I_RX_DATA;
    end
    if (tx_clr) begin
      tx_wp_nxt  = 4'h0;
      tx_rp_nxt  = 4'h0;
      tx_cnt_nxt = 5'h00;
    end
    if (rx_clr) begin
      rx_wp_nxt  = 4'h0;
      rx_rp_nxt  = 4'h0;
      rx_cnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge I_CLK) begin
    tx_mem_r  <= tx_mem_nxt;
    rx_mem_r  <= rx_mem_nxt;
    if (I_SYS_RST) begin
      tx_wp_r    <= 4'h0;
      tx_rp_r    <= 4'h0;
      rx_wp_r    <= 4'h0;
      rx_rp_r    <= 4'h0;
      tx_cnt_r   <= 5'h00;
      rx_cnt_r   <= 5'h00;
      tx_data_r  <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      tx_wp_r    <= tx_wp_nxt;
      tx_rp_r    <= tx_rp_nxt;
      rx_wp_r    <= rx_wp_nxt;
      rx_rp_r    <= rx_rp_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      tx_data_r  <= tx_mem_nxt[tx_rp_nxt];
      tx_valid_r <= (tx_cnt_nxt != 5'h00);
    end
  end

  // ==========================================================
  // Oscillator sync, bit ticks and receive timeout
  assign osc_tick = osc_r[1] && !osc_r[2];
  assign wl_bits  = {4'h0, line_control_reg_r[1:0]} + `URBG_WL_BASE;
  assign to_limit = {wl_bits[3:0], 2'b00} + `URBG_TO_EXTRA;

  always_comb begin
    osc_nxt      = {osc_r[1:0], I_OSC_IN};
    samp_nxt     = samp_r;
    bit_tick_nxt = 1'b0;
    to_cnt_nxt   = to_cnt_r;
    to_flag_nxt  = to_flag_r;
    if (sample_tick) begin
      samp_nxt     = samp_r + 4'h1;
      bit_tick_nxt = (samp_r == `URBG_SAMPLES_LAST);
    end
    if (rx_push || rx_pop || rx_clr || (rx_cnt_r == 5'h00)) begin
      to_cnt_nxt  = 6'h00;
      to_flag_nxt = 1'b0;
    end else if (bit_tick_r && !to_flag_r) begin
      to_cnt_nxt  = to_cnt_r + 6'h01;
      to_flag_nxt = ((to_cnt_r + 6'h01) >= to_limit);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      osc_r      <= 3'h0;
      samp_r     <= 4'h0;
      bit_tick_r <= 1'b0;
      to_cnt_r   <= 6'h00;
      to_flag_r  <= 1'b0;
    end else begin
      osc_r      <= osc_nxt;
      samp_r     <= samp_nxt;
      bit_tick_r <= bit_tick_nxt;
      to_cnt_r   <= to_cnt_nxt;
      to_flag_r  <= to_flag_nxt;
    end
  end

  urbg_baud_div u_baud (
    .i_clk         (I_CLK),
    .i_rst         (I_SYS_RST),
    .i_enable      (div_set_r == 2'h3),
    .i_prescale4   (modem_control_reg_r[`URBG_MODEM_PRESCALE]),
    .i_divisor     ({div_hi_r, div_lo_r}),
    .i_src_tick    (osc_tick),
    .o_sample_tick (sample_tick)
  );

  // ==========================================================
  // Interrupt and ready pins
  always_comb begin
    tx_int_nxt   = tx_int_r;
    rx_int_nxt   = rx_int_r;
    tx_rdy_n_nxt = tx_rdy_n_r;
    rx_rdy_n_nxt = rx_rdy_n_r;
    unique case (mode)
      URBG_MODE_SINGLE: begin
        tx_int_nxt   = (tx_cnt_nxt == 5'h00);
        rx_int_nxt   = (rx_cnt_nxt != 5'h00);
        rx_rdy_n_nxt = (rx_cnt_nxt == 5'h00);
        tx_rdy_n_nxt = (tx_cnt_nxt != 5'h00);
      end
      URBG_MODE_FIFO: begin
        tx_int_nxt   = (tx_cnt_nxt == 5'h00);
        rx_int_nxt   = (rx_cnt_nxt >= rx_trig);
        rx_rdy_n_nxt = (rx_cnt_nxt == 5'h00);
        tx_rdy_n_nxt = (tx_cnt_nxt != 5'h00);
      end
      URBG_MODE_BLOCK: begin
        tx_int_nxt   = !(tx_cnt_nxt > `URBG_TX_TRIG);
        rx_int_nxt   = (rx_cnt_nxt >= rx_trig);
        if (rx_cnt_nxt == 5'h00) begin
          rx_rdy_n_nxt = 1'b1;
        end else if ((rx_cnt_nxt >= rx_trig) || to_flag_nxt) begin
          rx_rdy_n_nxt = 1'b0;
        end
        tx_rdy_n_nxt = (tx_cnt_nxt >= `URBG_DEPTH);
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      tx_int_r   <= 1'b1;
      rx_int_r   <= 1'b0;
      tx_rdy_n_r <= 1'b0;
      rx_rdy_n_r <= 1'b1;
    end else begin
      tx_int_r   <= tx_int_nxt;
      rx_int_r   <= rx_int_nxt;
      tx_rdy_n_r <= tx_rdy_n_nxt;
      rx_rdy_n_r <= rx_rdy_n_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign O_PRDATA      = prdata_r;
  assign O_PREADY      = pready_r;
  assign O_PSLVERR     = pslverr_r;
  assign O_TX_DATA     = tx_data_r;
  assign O_TX_VALID    = tx_valid_r;
  assign O_SAMPLE_TICK = sample_tick;
  assign O_BIT_TICK    = bit_tick_r;
  assign O_WORD_LEN    = line_control_reg_r[1:0];
  assign O_TX_INT      = tx_int_r;
  assign O_RX_INT      = rx_int_r;
  assign O_TX_READY_N  = tx_rdy_n_r;
  assign O_RX_READY_N  = rx_rdy_n_r;
endmodule
`default_nettype wire

// ==== testbench/urbg_asserts.sv ====
// Checker of pin, tick and bus relations of urbg_top.
// Assumes it is bound to urbg_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "urbg_consts.svh"
module urbg_chk (
  // Clock, reset and bus
  input wire logic        I_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Channel outputs
  input wire logic        O_TX_VALID,
  input wire logic        O_SAMPLE_TICK,
  input wire logic        O_BIT_TICK,
  input wire logic        O_TX_INT,
  input wire logic        O_RX_INT,
  input wire logic        O_TX_READY_N,
  input wire logic        O_RX_READY_N
);
  logic [7:0] ctl_mirror_r;
  logic [7:0] ctl_mirror_d_r;
  logic [4:0] nst_r;
  logic       done;
  logic       pop;
  logic       stab;
  logic       blk;
  assign done = I_PSEL && I_PENABLE && O_PREADY && !O_PSLVERR;
  assign pop  = done && !I_PWRITE && I_PADDR == `URBG_ADDR_DATA;
  assign stab = ctl_mirror_r == ctl_mirror_d_r;
  assign blk  = ctl_mirror_r[0] && ctl_mirror_r[3];
  // ====================================================
  // Mirror of fifo control, sample ticks per bit
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctl_mirror_r   <= 8'h00;
      ctl_mirror_d_r <= 8'h00;
      nst_r   <= 5'h00;
    end else begin
      if (done && I_PWRITE && I_PADDR == `URBG_ADDR_FIFO_CTL) ctl_mirror_r <= I_PWDATA[7:0] & `URBG_FIFO_WMASK;
      ctl_mirror_d_r <= ctl_mirror_r;
      if (O_BIT_TICK) nst_r <= {4'h0, O_SAMPLE_TICK};
      else if (O_SAMPLE_TICK) nst_r <= nst_r + 5'h01;
    end
  end
  // ====================================================
  // Properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_rst;
    disable iff (1'b0) $fell(I_SYS_RST) |-> O_TX_INT && !O_RX_INT && !O_TX_READY_N && O_RX_READY_N;
  endproperty
  property p_tx_pair;
    stab && !blk |-> O_TX_INT == !O_TX_READY_N;
  endproperty
  property p_rx_single;
    stab && !ctl_mirror_r[0] |-> O_RX_INT == !O_RX_READY_N;
  endproperty
  property p_rx_int;
    stab && O_RX_INT |-> !O_RX_READY_N;
  endproperty
  property p_blk_full;
    stab && blk && O_TX_READY_N |-> !O_TX_INT;
  endproperty
  property p_blk_rise;
    stab && blk && $rose(O_RX_READY_N) |-> $past(pop) || $past(pop, 2);
  endproperty
  property p_wait;
    I_PSEL && I_PENABLE && !$past(I_PENABLE) |-> !O_PREADY ##1 O_PREADY;
  endproperty
  property p_line_stat;
    done && !I_PWRITE && I_PADDR == `URBG_ADDR_LINE_STAT |->
      O_PRDATA[5] == !$past(O_TX_VALID) && (O_PRDATA[5] || !O_PRDATA[6]);
  endproperty
  property p_bit16;
    O_BIT_TICK |-> nst_r == 5'h10;
  endproperty
  property p_tick;
    O_SAMPLE_TICK |=> !O_SAMPLE_TICK [*2];
  endproperty
  a_rst: assert property (p_rst) else $error("pins wrong after reset");
  a_tx_pair: assert property (p_tx_pair) else $error("tx int and tx ready disagree");
  a_rx_single: assert property (p_rx_single) else $error("rx int and rx ready disagree");
  a_rx_int: assert property (p_rx_int) else $error("rx int without rx ready");
  a_blk_full: assert property (p_blk_full) else $error("full tx with tx int high");
  a_blk_rise: assert property (p_blk_rise) else $error("rx ready rose without a read");
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  a_line_stat: assert property (p_line_stat) else $error("line status tx bits wrong");
  a_bit16: assert property (p_bit16) else $error("bit tick not after 16 samples");
  a_tick: assert property (p_tick) else $error("sample ticks too close");
  c_blk: cover property (blk && $fell(O_RX_READY_N));
  c_full: cover property (blk && O_TX_READY_N);
  c_bit: cover property (O_BIT_TICK);
endmodule
bind urbg_top urbg_chk chk_i (.I_CLK, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
  .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_TX_VALID, .O_SAMPLE_TICK, .O_BIT_TICK, .O_TX_INT, .O_RX_INT,
  .O_TX_READY_N, .O_RX_READY_N);
`default_nettype wire

// ==== testbench/urbg_link_model.sv ====
// Serial side stand-in: oscillator, tx shifter pops, rx pushes.
// Assumes the clock of urbg_top; tasks are entered after an edge.
`timescale 1ns/1ps
`default_nettype none
module urbg_link_model (
  // Clock
  input  wire logic  i_clk,
  // Toward the channel
  output logic       o_osc,
  output logic       o_tx_pop,
  output logic       o_shift_empty,
  output logic       o_rx_push,
  output logic [7:0] o_rx_data
);
  logic osc_run;
  logic ph_r;
  initial begin
    osc_run = 1'b0;
    ph_r = 1'b0;
    o_osc = 1'b0;
    o_tx_pop = 1'b0;
    o_shift_empty = 1'b1;
    o_rx_push = 1'b0;
    o_rx_data = 8'hFF;
  end
  // Oscillator, four clocks a period
  always @(posedge i_clk) begin
    if (osc_run) begin
      ph_r <= !ph_r;
      if (ph_r) o_osc <= !o_osc;
    end
  end
  task automatic pop;
    @(posedge i_clk);
    o_tx_pop <= 1'b1;
    o_shift_empty <= 1'b0;
    @(posedge i_clk);
    o_tx_pop <= 1'b0;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_push <= 1'b1;
    o_rx_data <= b;
    @(posedge i_clk);
    o_rx_push <= 1'b0;
    o_rx_data <= ~b;
  endtask
  task automatic shift_done;
    o_shift_empty <= 1'b1;
  endtask
  task automatic start_osc;
    osc_run <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/urbg_tb_top.sv ====
// Bench of urbg_top: ready pins, modes, line status, baud ticks.
// Assumes urbg_link_model on the serial side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "urbg_consts.svh"
module urbg_tb_top;
  import urbg_pkg::*;
  // Timeout with word field 2, divisor 1: bit ticks times 64 clocks
  localparam int TO = (4 * (2 + 5) + 12) * 64;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        osc, tpop, sempty, push, txv, stk, btk, txi, rxi, txrn, rxrn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  wl;
  urbg_byte_t  txd, rxd;
  int          n_fail, n_tests;
  urbg_top uut (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_OSC_IN(osc), .I_TX_POP(tpop), .I_TX_SHIFT_EMPTY(sempty), .O_TX_DATA(txd), .O_TX_VALID(txv),
    .I_RX_PUSH(push), .I_RX_DATA(rxd), .O_SAMPLE_TICK(stk), .O_BIT_TICK(btk), .O_WORD_LEN(wl),
    .O_TX_INT(txi), .O_RX_INT(rxi), .O_TX_READY_N(txrn), .O_RX_READY_N(rxrn));
  urbg_link_model lnk (.i_clk(clk), .o_osc(osc), .o_tx_pop(tpop), .o_shift_empty(sempty),
    .o_rx_push(push), .o_rx_data(rxd));
  // ====================================================
  // Shared tasks
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 20) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Pins as {tx int, rx int, tx ready_n, rx ready_n}
  task automatic pin(input logic [3:0] e);
    repeat (2) @(posedge clk);
    chk("pins", {28'h0000000, e}, {28'h0000000, txi, rxi, txrn, rxrn});
  endtask
  task automatic line_stat(input logic [7:0] e);
    apb(1'b0, `URBG_ADDR_LINE_STAT, 8'h00);
    chk("line status", {24'h000000, e}, rd & 32'h00000061);
  endtask
  task automatic gap(input logic w, input int e);
    int n;
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((w ? btk : stk) !== 1'b1 && n < 2000);
      if (n >= 2000) begin
        n_fail++;
        print_verdict();
      end
    end
    chk("tick gap", e, n);
  endtask
  // ====================================================
  // Scenarios
  task automatic t_reset;
    pin(4'h9);
    apb(1'b1, `URBG_ADDR_FIFO_CTL, 8'hFF);
    apb(1'b0, `URBG_ADDR_FIFO_CTL, 8'h00);
    chk("fifo ctl", 32'h000000C9, rd);
    apb(1'b1, `URBG_ADDR_FIFO_CTL, 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    chk("bad addr", 32'h00000001, {31'h0, err});
    chk("bad data", 32'h00000000, rd);
  endtask
  task automatic t_single;
    apb(1'b1, `URBG_ADDR_DATA, 8'hA5);
    pin(4'h3);
    chk("tx data", 32'h000000A5, {24'h000000, txd});
    line_stat(8'h00);
    lnk.pop();
    pin(4'h9);
    line_stat(8'h20);
    lnk.shift_done();
    line_stat(8'h60);
    lnk.push(8'h3C);
    lnk.push(8'hC3);
    pin(4'hC);
    apb(1'b0, `URBG_ADDR_DATA, 8'h00);
    chk("rx data", 32'h0000003C, rd);
    pin(4'h9);
  endtask
  task automatic t_fifo;
    apb(1'b1, `URBG_ADDR_FIFO_CTL, 8'h41);
    pin(4'h9);
    apb(1'b1, `URBG_ADDR_DATA, 8'h11);
    apb(1'b1, `URBG_ADDR_DATA, 8'h22);
    pin(4'h3);
    lnk.pop();
    pin(4'h3);
    chk("tx head", 32'h00000022, {24'h000000, txd});
    lnk.pop();
    pin(4'h9);
    for (int i = 1; i <= 4; i++) begin
      lnk.push(i[7:0]);
      if (i == 3) pin(4'h8);
    end
    pin(4'hC);
    for (int i = 1; i <= 4; i++) begin
      apb(1'b0, `URBG_ADDR_DATA, 8'h00);
      chk("rx data", i, rd);
    end
    pin(4'h9);
  endtask
  task automatic t_block;
    apb(1'b1, `URBG_ADDR_FIFO_CTL, 8'h49);
    for (int i = 1; i <= 17; i++) begin
      apb(1'b1, `URBG_ADDR_DATA, i[7:0]);
      if (i == 8) pin(4'h9);
      if (i == 9) pin(4'h1);
      if (i == 15) pin(4'h1);
    end
    pin(4'h3);
    lnk.pop();
    pin(4'h1);
    repeat (15) lnk.pop();
    pin(4'h9);
    for (int i = 1; i <= 4; i++) begin
      lnk.push(8'h5A);
      if (i == 3) pin(4'h9);
    end
    pin(4'hC);
    apb(1'b0, `URBG_ADDR_DATA, 8'h00);
    pin(4'h8);
    repeat (3) apb(1'b0, `URBG_ADDR_DATA, 8'h00);
    pin(4'h9);
  endtask
  task automatic t_baud;
    lnk.start_osc();
    apb(1'b1, `URBG_ADDR_DIV_LO, 8'h03);
    apb(1'b1, `URBG_ADDR_DIV_HI, 8'h00);
    gap(1'b0, 12);
    apb(1'b1, `URBG_ADDR_MODEM_CTL, 8'h80);
    gap(1'b0, 48);
    gap(1'b1, 768);
  endtask
  task automatic t_tout;
    apb(1'b1, `URBG_ADDR_MODEM_CTL, 8'h00);
    apb(1'b1, `URBG_ADDR_DIV_LO, 8'h01);
    apb(1'b1, `URBG_ADDR_LINE_CTL, 8'h02);
    chk("word len", 32'h00000002, {30'h0, wl});
    lnk.push(8'h77);
    repeat (TO - 160) @(posedge clk);
    pin(4'h9);
    repeat (300) @(posedge clk);
    pin(4'h8);
    apb(1'b0, `URBG_ADDR_DATA, 8'h00);
    pin(4'h9);
  endtask
  // ====================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_single();
    t_fifo();
    t_block();
    t_baud();
    t_tout();
    print_verdict();
  end
endmodule
`default_nettype wire
